// >>> adc_output_reset_alert_regs.sv
// lane select, reset command and sticky fault registers behind the serial frame port
//
// What this block does
// - select 00: results on lanes a and b
// - select 01 or 11: lane a only
// - select 10: four lanes, d shares alert pin
// - code 3c: soft reset, clear faults, flush
// - code ff: hard reset, all registers default
// - other codes cause no reset action
// - bad write checksum sets sticky flag 9
// - setup flag 8 cleared by hard reset only
// - channel d high sets sticky flag 7
// - readback bits 15:12 carry register address
// - frame: write flag, address, twelve data
// - read request answered in the next frame
// - checksum-less write dropped, raises flag 9
`default_nettype none

module adc_output_reset_alert_regs
  import adc_regs_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SERIAL_IN,
  input wire logic I_CRC_WRITE_EN,
  input wire logic I_ALERT_EN,
  input wire logic I_SETUP_FAIL,
  input wire logic I_CHAN_D_HIGH,
  output logic O_LANE_A,
  output logic [1:0] O_LANE_SEL,
  output logic O_LANE_B_EN,
  output logic O_LANE_C_EN,
  output logic O_LANE_D_DATA_EN,
  output logic O_ALERT,
  output logic O_SOFT_RESET,
  output logic O_HARD_RESET
);

  ////////////////////////////////////////////////////////////////////////////////
  // checksum over one 16-bit frame, msb first
  function automatic logic [7:0] crc8(input logic [15:0] word);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ word[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  ////////////////////////////////////////////////////////////////////////////////
  // link side and crossings
  logic [15:0] link_word;   // last frame, stable for a whole frame after its toggle
  logic [7:0] link_crc;     // last checksum byte, same stability
  logic word_tgl;           // flips once per 16-bit frame
  logic crc_tgl;            // flips once per checksum byte
  logic word_evt;           // core pulse: a frame has arrived
  logic crc_evt;            // core pulse: its checksum has arrived
  logic [15:0] out_word_q;  // readback word, quasi-static towards the link

  serial_link u_link (
    .i_sclk(I_SCLK),
    .i_rst_n(I_RSTN),
    .i_cs_n(I_CS_N),
    .i_serial_in(I_SERIAL_IN),
    .i_out_word(out_word_q),
    .o_frame_word(link_word),
    .o_word_tgl(word_tgl),
    .o_crc_byte(link_crc),
    .o_crc_tgl(crc_tgl),
    .o_lane_a(O_LANE_A)
  );

  // the data words are only read after their toggle has been synchronised
  toggle_sync u_word_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RSTN),
    .i_tgl(word_tgl),
    .o_pulse(word_evt)
  );

  toggle_sync u_crc_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RSTN),
    .i_tgl(crc_tgl),
    .o_pulse(crc_evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] lane_sel_q;     // output_lane_select field
  logic [7:0] reset_code_q;   // last reset command written; 00 again once a hard reset has acted
  logic [2:0] flags_q;        // {write crc error, setup error, chan d high}
  logic pend_q;               // a write waits for its checksum
  logic [15:0] pend_word_q;   // that write
  logic clr_pend_q;           // fault_flags readback is on its way out

  ////////////////////////////////////////////////////////////////////////////////
  // frame decode
  wire logic f_wr = link_word[WR_FLAG_POS];
  wire logic [2:0] f_addr = link_word[ADDR_LSB +: 3];
  wire logic crc_ok = (crc8(pend_word_q) == link_crc);
  // with protection on, a write only counts once a matching checksum follows
  wire logic write_go = I_CRC_WRITE_EN ? (crc_evt && pend_q && crc_ok)
                                       : (word_evt && f_wr);
  wire logic [15:0] wr_word = I_CRC_WRITE_EN ? pend_word_q : link_word;
  // bad checksum, or a new frame where a checksum was due, drops the write
  wire logic crc_bad = I_CRC_WRITE_EN && pend_q
                       && ((crc_evt && !crc_ok) || word_evt);
  wire logic cfg_wr = write_go && (wr_word[ADDR_LSB +: 3] == CFG2_ADDR);
  wire logic [7:0] wr_code = wr_word[7:0];
  wire logic soft_go = cfg_wr && (wr_code == SOFT_RESET_CODE);
  wire logic hard_go = cfg_wr && (wr_code == HARD_RESET_CODE);
  wire logic read_evt = word_evt && !f_wr;
  // the frame after a fault_flags read has shifted the snapshot out
  wire logic rb_done = word_evt && clr_pend_q;

  ////////////////////////////////////////////////////////////////////////////////
  // fault flag masks; set beats clear in the same cycle
  wire logic [2:0] set_mask = {crc_bad, I_SETUP_FAIL, I_CHAN_D_HIGH};
  wire logic [2:0] rb_clear = rb_done ? (out_word_q[FLAG_LSB +: 3] & READ_CLEAR_MASK)
                                      : 3'h0;
  // setup error only leaves on a hard reset
  wire logic [2:0] clr_mask = (hard_go ? HARD_CLEAR_MASK : 3'h0)
                              | (soft_go ? SOFT_CLEAR_MASK : 3'h0) | rb_clear;
  wire logic [2:0] flags_d = (flags_q & ~clr_mask) | set_mask;

  // next configuration; reserved bits 11:10 are simply never stored
  wire logic [1:0] lane_sel_d = hard_go ? LANE_SEL_RST
                                : cfg_wr ? wr_word[LANE_SEL_LSB +: 2] : lane_sel_q;
  wire logic [7:0] reset_code_d = hard_go ? RESET_CODE_RST
                                  : cfg_wr ? wr_code : reset_code_q;

  // readback words carry the address on top and zero reserved bits
  wire logic [15:0] cfg_rb = {1'b0, CFG2_ADDR, 2'b00, lane_sel_q, reset_code_q};
  wire logic [15:0] alert_rb = {1'b0, ALERT_ADDR, 2'b00, flags_d, 7'h00};
  wire logic [15:0] read_word = (f_addr == CFG2_ADDR) ? cfg_rb
                                : (f_addr == ALERT_ADDR) ? alert_rb : OUT_WORD_RST;
  // a read request parks its answer for the next frame; any other frame drops it
  wire logic [15:0] out_word_d = read_evt ? read_word
                                 : word_evt ? OUT_WORD_RST : out_word_q;

  // lane outputs follow the select field
  wire logic b_en_d = (lane_sel_q == LANE_TWO) || (lane_sel_q == LANE_FOUR);
  wire logic four_d = (lane_sel_q == LANE_FOUR);
  // alert function only with select 01 (LANE_ONE) and the enable set, not with select 11
  wire logic alert_d = I_ALERT_EN && (lane_sel_q == LANE_ONE) && (flags_q != 3'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // checksum bookkeeping: only writes need one
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pend_q <= 1'b0;
      pend_word_q <= '0;
    end else if (!I_CRC_WRITE_EN) begin
      pend_q <= 1'b0;
    end else if (word_evt && f_wr) begin
      pend_q <= 1'b1;
      pend_word_q <= link_word;
    end else if (crc_evt || word_evt) begin
      pend_q <= 1'b0;
    end
  end

  // register state
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lane_sel_q <= LANE_SEL_RST;
      reset_code_q <= RESET_CODE_RST;
      flags_q <= FLAGS_RST;
      out_word_q <= OUT_WORD_RST;
      clr_pend_q <= 1'b0;
    end else begin
      lane_sel_q <= lane_sel_d;
      reset_code_q <= reset_code_d;
      flags_q <= flags_d;
      out_word_q <= out_word_d;
      clr_pend_q <= read_evt ? (f_addr == ALERT_ADDR) : (word_evt ? 1'b0 : clr_pend_q);
    end
  end

  // registered outputs; reset pulses last one cycle, other codes stay quiet
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_LANE_SEL <= LANE_SEL_RST;
      O_LANE_B_EN <= 1'b1;
      O_LANE_C_EN <= 1'b0;
      O_LANE_D_DATA_EN <= 1'b0;
      O_ALERT <= 1'b0;
      O_SOFT_RESET <= 1'b0;
      O_HARD_RESET <= 1'b0;
    end else begin
      O_LANE_SEL <= lane_sel_q;
      O_LANE_B_EN <= b_en_d;
      O_LANE_C_EN <= four_d;
      O_LANE_D_DATA_EN <= four_d;
      O_ALERT <= alert_d;
      O_SOFT_RESET <= soft_go;
      O_HARD_RESET <= hard_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  chk_two_lane_out: assert property (
    (lane_sel_q == LANE_TWO) ##1 (lane_sel_q == LANE_TWO)
    |-> O_LANE_B_EN && !O_LANE_C_EN && !O_LANE_D_DATA_EN)
    else $error("two-lane mode lanes wrong");

  chk_one_lane_out: assert property (
    (lane_sel_q[0]) ##1 (lane_sel_q[0]) |-> !O_LANE_B_EN && !O_LANE_C_EN)
    else $error("one-lane mode drives extra lanes");

  chk_four_lane_out: assert property (
    (lane_sel_q == LANE_FOUR) ##1 (lane_sel_q == LANE_FOUR)
    |-> O_LANE_B_EN && O_LANE_C_EN && O_LANE_D_DATA_EN && !O_ALERT)
    else $error("four-lane mode lanes wrong");

  chk_soft_reset_act: assert property (
    soft_go && !crc_bad && !I_CHAN_D_HIGH
    |=> O_SOFT_RESET && !flags_q[2] && !flags_q[0] && (reset_code_q == SOFT_RESET_CODE))
    else $error("soft reset did not act");

  chk_hard_reset_act: assert property (
    hard_go |=> O_HARD_RESET && (lane_sel_q == LANE_SEL_RST)
    && (reset_code_q == RESET_CODE_RST) ##1 !O_HARD_RESET)
    else $error("hard reset did not restore defaults");

  chk_no_reset_other: assert property (
    cfg_wr && (wr_code != SOFT_RESET_CODE) && (wr_code != HARD_RESET_CODE)
    |=> !O_SOFT_RESET && !O_HARD_RESET)
    else $error("reset fired on a foreign code");

  chk_crc_flag_set: assert property (
    crc_bad |=> flags_q[2] && $stable(lane_sel_q))
    else $error("bad checksum not flagged or write taken");

  chk_setup_sticky: assert property (
    flags_q[1] && !hard_go |=> flags_q[1])
    else $error("setup error cleared without hard reset");

  chk_chan_d_flag: assert property (
    I_CHAN_D_HIGH |=> flags_q[0])
    else $error("channel d high not flagged");

  chk_readback_addr: assert property (
    read_evt && (f_addr == ALERT_ADDR || f_addr == CFG2_ADDR)
    |=> out_word_q[15:12] == {1'b0, $past(f_addr)})
    else $error("readback address field wrong");

  chk_reserved_zero: assert property (
    out_word_q[11:10] == 2'b00)
    else $error("reserved readback bits not zero");

  chk_flag_snapshot: assert property (
    read_evt && (f_addr == ALERT_ADDR)
    |=> (out_word_q[FLAG_LSB +: 3] == $past(flags_d)) && clr_pend_q)
    else $error("fault snapshot wrong");

  // flag clearing and reset pulse origin; these guard the paths that a
  // stuck read-clear or a stray strobe would break without any lane change

  // a channel d flag that went out in the snapshot is gone once the word has left
  chk_chan_d_clear: assert property (
    rb_done && out_word_q[FLAG_LSB] && !I_CHAN_D_HIGH |=> !flags_q[0])
    else $error("channel d flag not cleared by read");

  // same for the checksum error; a drop in the clearing cycle keeps it set
  chk_crc_flag_clear: assert property (
    rb_done && out_word_q[FLAG_LSB + 2] && !crc_bad |=> !flags_q[2])
    else $error("checksum flag not cleared by read");

  // only a hard reset takes the setup error away
  chk_setup_hard_clear: assert property (
    hard_go && !I_SETUP_FAIL |=> !flags_q[1])
    else $error("setup error survived hard reset");

  // a rejected write never reaches the configuration
  chk_crc_drop_write: assert property (
    crc_bad |-> !cfg_wr)
    else $error("write taken despite bad checksum");

  // reset pulses only ever follow one of the two command codes
  chk_reset_pulse_src: assert property (
    (O_SOFT_RESET || O_HARD_RESET) |-> $past(soft_go || hard_go))
    else $error("reset pulse without its command code");

  // main scenarios: both reset kinds, a read-clear cycle, a drop, four lanes
  cov_soft_reset: cover property (soft_go);
  cov_hard_reset: cover property (hard_go);
  cov_alert_read: cover property (read_evt && (f_addr == ALERT_ADDR) ##[1:200] rb_done);
  cov_crc_reject: cover property (crc_bad);
  cov_four_lane: cover property (lane_sel_q == LANE_FOUR);

endmodule : adc_output_reset_alert_regs

`default_nettype wire

// >>> adc_output_reset_alert_regs_tb.sv
// self-checking bench for the lane select, reset command and fault flag registers
`default_nettype none

module adc_output_reset_alert_regs_tb
  import adc_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rstn, sclk, cs_n, serial_in, crc_en, alert_en, setup_fail, chan_d_high;
  logic lane_a, b_en, c_en, d_en, alert, soft_rst, hard_rst;
  logic [1:0] lane_sel;
  logic [15:0] w;
  int errors, n_tests, soft_cnt, hard_cnt, s0, h0;
  logic [7:0] codes [5] = '{8'h55, 8'h3c, 8'hfe, 8'h00, 8'hff};

  adc_output_reset_alert_regs dut (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_SERIAL_IN(serial_in), .I_CRC_WRITE_EN(crc_en), .I_ALERT_EN(alert_en),
    .I_SETUP_FAIL(setup_fail), .I_CHAN_D_HIGH(chan_d_high), .O_LANE_A(lane_a),
    .O_LANE_SEL(lane_sel), .O_LANE_B_EN(b_en), .O_LANE_C_EN(c_en),
    .O_LANE_D_DATA_EN(d_en), .O_ALERT(alert), .O_SOFT_RESET(soft_rst),
    .O_HARD_RESET(hard_rst)
  );

  host_link_model host (
    .o_sclk(sclk), .o_serial_in(serial_in), .o_cs_n(cs_n), .i_lane_a(lane_a)
  );

  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // count the one-cycle reset pulses
  always @(posedge clk) begin
    if (soft_rst === 1'b1) soft_cnt++;
    if (hard_rst === 1'b1) hard_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // expected lane outputs for a select value
  function automatic logic [15:0] lanes_exp(input logic [1:0] s);
    return {11'h0, s, (s == LANE_TWO) || (s == LANE_FOUR), s == LANE_FOUR, s == LANE_FOUR};
  endfunction : lanes_exp

  function automatic logic [15:0] lanes_now();
    return {11'h0, lane_sel, b_en, c_en, d_en};
  endfunction : lanes_now

  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    logic [15:0] dummy;
    host.xfer({1'b1, a, d}, crc_en, 8'h00, dummy);
  endtask : wr

  // read request, then a neutral frame that carries the answer out
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] r);
    logic [15:0] dummy;
    host.xfer({1'b0, a, 12'h000}, crc_en, 8'h00, dummy);
    host.xfer(16'h0000, crc_en, 8'h00, r);
  endtask : rd_reg

  task automatic pulse(input logic to_d);
    @(posedge clk);
    if (to_d) chan_d_high <= 1'b1;
    else setup_fail <= 1'b1;
    @(posedge clk);
    chan_d_high <= 1'b0;
    setup_fail <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the run needs well under 100 us
  initial begin
    #300us;
    errors++;
    $display("Error watchdog expired");
    end_sim();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    crc_en = 1'b0;
    alert_en = 1'b0;
    setup_fail = 1'b0;
    chan_d_high = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset lanes", lanes_exp(LANE_SEL_RST), lanes_now());
    rd_reg(ALERT_ADDR, w);
    chk("fault_flags after reset", {1'b0, ALERT_ADDR, 12'h000}, w);
    // every select code, with the reserved bits written as ones
    for (int s = 0; s < 4; s++) begin
      wr(CFG2_ADDR, {2'h3, 2'(s), 8'h00});
      chk("lane outputs", lanes_exp(2'(s)), lanes_now());
      rd_reg(CFG2_ADDR, w);
      chk("config readback", {1'b0, CFG2_ADDR, 2'h0, 2'(s), 8'h00}, w);
    end
    // every kind of reset code
    foreach (codes[i]) begin
      s0 = soft_cnt;
      h0 = hard_cnt;
      wr(CFG2_ADDR, {2'h0, LANE_ONE, codes[i]});
      chk("soft pulses", 16'(codes[i] == SOFT_RESET_CODE), 16'(soft_cnt - s0));
      chk("hard pulses", 16'(codes[i] == HARD_RESET_CODE), 16'(hard_cnt - h0));
      rd_reg(CFG2_ADDR, w);
      chk("config after code", (codes[i] == HARD_RESET_CODE) ? 16'h2000 :
          {1'b0, CFG2_ADDR, 2'h0, LANE_ONE, codes[i]}, w);
    end
    // writes to an unmapped place and to the read-only flags are ignored
    h0 = hard_cnt;
    wr(3'h5, 12'h0ff);
    wr(ALERT_ADDR, 12'hfff);
    chk("unmapped write", 16'h0000, 16'(hard_cnt - h0));
    rd_reg(ALERT_ADDR, w);
    chk("flags after write", 16'h3000, w);
    // a read of an unmapped place answers with zero
    rd_reg(3'h6, w);
    chk("unmapped read", 16'h0000, w);
    // sticky flags, alert pin in single-lane mode
    wr(CFG2_ADDR, {2'h0, LANE_ONE, 8'h00});
    @(posedge clk);
    alert_en <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    chk("alert pin", 16'h0001, 16'(alert));
    rd_reg(ALERT_ADDR, w);
    chk("flags snapshot", 16'h3180, w);
    rd_reg(ALERT_ADDR, w);
    chk("flags after read", 16'h3100, w);
    @(posedge clk);
    alert_en <= 1'b0;
    pulse(1'b1);
    chk("alert disabled", 16'h0000, 16'(alert));
    wr(CFG2_ADDR, {2'h0, LANE_ONE, SOFT_RESET_CODE});
    rd_reg(ALERT_ADDR, w);
    chk("flags after soft", 16'h3100, w);
    // event after the request is not in the answer and survives its clear
    host.xfer(16'h3000, 1'b0, 8'h00, w);
    pulse(1'b1);
    host.xfer(16'h0000, 1'b0, 8'h00, w);
    chk("snapshot at request", 16'h3100, w);
    rd_reg(ALERT_ADDR, w);
    chk("late event kept", 16'h3180, w);
    wr(CFG2_ADDR, {2'h0, LANE_ONE, HARD_RESET_CODE});
    rd_reg(ALERT_ADDR, w);
    chk("flags after hard", 16'h3000, w);
    // checksum protected writes
    @(posedge clk);
    crc_en <= 1'b1;
    @(posedge clk);
    host.xfer({1'b1, CFG2_ADDR, 2'h0, LANE_FOUR, 8'h00}, 1'b1, 8'h5a, w);
    chk("bad checksum dropped", lanes_exp(LANE_TWO), lanes_now());
    rd_reg(ALERT_ADDR, w);
    chk("checksum flag", 16'h3200, w);
    rd_reg(ALERT_ADDR, w);
    chk("checksum flag read", 16'h3000, w);
    wr(CFG2_ADDR, {2'h0, LANE_FOUR, 8'h00});
    chk("good checksum", lanes_exp(LANE_FOUR), lanes_now());
    // a write whose checksum never comes is dropped by the next frame
    host.xfer({1'b1, CFG2_ADDR, 2'h0, LANE_ONE, 8'h00}, 1'b0, 8'h00, w);
    rd_reg(ALERT_ADDR, w);
    chk("write without checksum", 16'h3200, w);
    chk("lanes kept", lanes_exp(LANE_FOUR), lanes_now());
    end_sim();
  end

endmodule : adc_output_reset_alert_regs_tb

`default_nettype wire

// >>> adc_regs_pkg.sv
// constants shared by the lane/reset/fault register logic and its serial front end
`default_nettype none

package adc_regs_pkg;

  // serial frame layout
  localparam int FRAME_BITS = 16;              // bits in one register frame
  localparam int CRC_BITS = 8;                 // bits in the trailing write checksum
  localparam int WR_FLAG_POS = 15;             // write flag position in a frame
  localparam int ADDR_LSB = 12;                // low bit of the 3-bit register select
  localparam int BIT_CNT_W = 5;                // width of the link bit counter
  localparam logic [4:0] LAST_WORD_BIT = 5'h0f;  // count at the 16th edge
  localparam logic [4:0] LAST_CRC_BIT = 5'h17;   // count at the 24th edge
  localparam logic [4:0] CNT_SAT = 5'h1f;        // counter stops here

  // register selects
  localparam logic [2:0] CFG2_ADDR = 3'h2;     // output_and_reset_config
  localparam logic [2:0] ALERT_ADDR = 3'h3;    // fault_flags

  // output_and_reset_config fields and reset values
  localparam int LANE_SEL_LSB = 8;             // lane select field [9:8]
  localparam logic [1:0] LANE_SEL_RST = 2'h0;  // two lanes after reset
  localparam logic [1:0] LANE_TWO = 2'h0;      // lanes a and b
  localparam logic [1:0] LANE_ONE = 2'h1;      // lane a only
  localparam logic [1:0] LANE_FOUR = 2'h2;     // lanes a to d
  localparam logic [7:0] RESET_CODE_RST = 8'h00;  // reset command field after reset
  localparam logic [7:0] SOFT_RESET_CODE = 8'h3c; // keep registers, clear faults
  localparam logic [7:0] HARD_RESET_CODE = 8'hff; // everything back to defaults

  // fault_flags layout, held as three bits [9:7]
  localparam int FLAG_LSB = 7;                 // lowest flag position in the word
  localparam logic [2:0] FLAGS_RST = 3'h0;     // flags after reset
  localparam logic [2:0] READ_CLEAR_MASK = 3'h5;  // write crc and chan d high clear on read
  localparam logic [2:0] SOFT_CLEAR_MASK = 3'h5;  // setup error survives a soft reset
  localparam logic [2:0] HARD_CLEAR_MASK = 3'h7;  // hard reset clears everything

  // checksum polynomial x^8 + x^2 + x + 1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [15:0] OUT_WORD_RST = 16'h0000;  // readback word after reset

endpackage : adc_regs_pkg

`default_nettype wire

// >>> host_link_model.sv
// host-side serial controller model: sends frames, samples readback words on lane a
`default_nettype none

module host_link_model
  import adc_regs_pkg::*;
(
  output logic o_sclk,
  output logic o_serial_in,
  output logic o_cs_n,
  input wire logic i_lane_a
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: clock stands still low, frame deselected
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_serial_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write checksum: poly 0x07, init 0, msb first over the 16 frame bits
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  ////////////////////////////////////////////////////////////////////////////////
  // one frame; bad is xored into the checksum to corrupt it on purpose
  task automatic xfer(
    input logic [15:0] w,
    input logic crc_on,
    input logic [7:0] bad,
    output logic [15:0] rd
  );
    logic [23:0] bits;
    int n;
    bits = {w, crc8(w) ^ bad};
    n = (crc_on && w[WR_FLAG_POS]) ? 24 : 16; // reads carry no checksum
    #3.7; // odd offset keeps the link edges off the core edges
    o_cs_n = 1'b0;
    for (int k = 23; k > 23 - n; k--) begin
      o_serial_in = bits[k]; // msb first, set while the clock is low
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
      if (k > 7) begin
        rd[k - 8] = i_lane_a; // sampled on the falling edge
      end
    end
    #16 o_cs_n = 1'b1;
    o_serial_in = ~o_serial_in; // released line shows no stale value
    #100; // deselect gap well above 64 ns
  endtask : xfer

endmodule : host_link_model

`default_nettype wire

// >>> serial_link.sv
// link-clock front end: shifts frames in, readback words out on lane a
`default_nettype none

module serial_link
  import adc_regs_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_serial_in,
  input wire logic [15:0] i_out_word,
  output logic [15:0] o_frame_word,
  output logic o_word_tgl,
  output logic [7:0] o_crc_byte,
  output logic o_crc_tgl,
  output logic o_lane_a
);

  logic [BIT_CNT_W-1:0] cnt_q;   // edges seen in this frame
  logic [15:0] sh_in_q;          // incoming bits, msb first
  logic [15:0] sh_out_q;         // remaining readback bits

  wire logic first_edge = (cnt_q == '0);
  wire logic word_done = (cnt_q == LAST_WORD_BIT);
  wire logic crc_done = (cnt_q == LAST_CRC_BIT);
  wire logic [15:0] in_next = {sh_in_q[14:0], i_serial_in};

  // bit counter: chip select high clears it, since the clock stops between frames
  always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n || i_cs_n) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_SAT) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // shifters and handover registers; words stay put for a whole frame
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_in_q <= '0;
      sh_out_q <= '0;
      o_frame_word <= '0;
      o_word_tgl <= 1'b0;
      o_crc_byte <= '0;
      o_crc_tgl <= 1'b0;
      o_lane_a <= 1'b0;
    end else if (!i_cs_n) begin
      sh_in_q <= in_next;
      // readback word was parked by the core long before this frame began
      if (first_edge) begin
        o_lane_a <= i_out_word[15];
        sh_out_q <= {i_out_word[14:0], 1'b0};
      end else begin
        o_lane_a <= sh_out_q[15];
        sh_out_q <= {sh_out_q[14:0], 1'b0};
      end
      // 16 bits make one frame
      if (word_done) begin
        o_frame_word <= in_next;
        o_word_tgl <= ~o_word_tgl;
      end
      // eight more bits are the write checksum
      if (crc_done) begin
        o_crc_byte <= in_next[7:0];
        o_crc_tgl <= ~o_crc_tgl;
      end
    end
  end

endmodule : serial_link

`default_nettype wire

// >>> toggle_sync.sv
// two-flop synchroniser for a toggle, giving a one-cycle pulse per toggle
`default_nettype none

module toggle_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tgl,
  output logic o_pulse
);

  logic meta_q;   // first stage, read only by the second
  logic sync_q;   // second stage
  logic last_q;   // previous synced value for edge finding

  // plain double flop then one more stage to find a change
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= i_tgl;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // any change of the synced level is one event
  assign o_pulse = sync_q ^ last_q;

endmodule : toggle_sync

`default_nettype wire
